// *** core/wfd_detector.sv ***
// Wake frame detector: exact, broadcast, pattern and CRC-16 filter wake, APB registers
// Overview of operation
// - exact destination address match flags wake
// - wake only with good FCS and length
// - all-ones destination flags broadcast wake
// - match sets source bit, status, interrupt
// - pattern: addressed frame, sync, sixteen copies
// - broken copy run restarts sync search
// - copies count only right after sync
// - filter checking starts at pattern offset
// - mask bit j selects byte offset+j
// - CRC-16 of selected bytes versus expected
// - address, multicast, broadcast results ORed
// - unicast wakes unless address match fails
// - multicast per its enable or exact match with matching on, broadcast per its enable
// - filter wake sets filter status bit
// - wake output held until status cleared
// - interrupt held until software clears it
// - filter CRC starts at all ones
// - offset zero is first destination byte
`timescale 1ns/1ps
module wfd_detector (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Register bus
   input wire wfd_pkg::wfd_apb_req_t apb_req,
   output wfd_pkg::wfd_apb_rsp_t apb_rsp,
   // Received frame bytes
   input wire wfd_pkg::wfd_rx_t rx,
   // Wake indications
   output logic irq_out_n,
   output logic wake_event_out_n
);
   wfd_pkg::wfd_state_t s_q;
   wfd_pkg::wfd_state_t s_d;
   logic [15:0] crc_step;

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   function automatic logic reg_mapped(input logic [7:0] a);
      reg_mapped = (a[1:0] == 2'b00) && (a <= wfd_pkg::OFS_IRQ_SRC);
   endfunction

   function automatic logic [7:0] addr_byte(input logic [47:0] addr, input logic [2:0] k);
      addr_byte = addr[8 * k +: 8];
   endfunction

   // Byte mask words sit in one run of four aligned words
   function automatic logic in_mask(input logic [7:0] a);
      in_mask = (a >= wfd_pkg::OFS_MASK0) && (a <= wfd_pkg::OFS_MASK3);
   endfunction

   function automatic logic [1:0] mask_word(input logic [7:0] a);
      mask_word = 2'((a - wfd_pkg::OFS_MASK0) >> 2);
   endfunction

   // Filter address qualification; the three results are ORed
   function automatic logic filter_addr_ok(
      input logic uni,
      input logic mcast,
      input logic bcast,
      input logic da_ok,
      input logic amatch_en,
      input logic any_mc_en,
      input logic bc_en
   );
      logic by_addr;
      logic by_group;
      // Unicast passes unless matching is on and the address differs
      by_addr = uni && (!amatch_en || da_ok);
      by_group = mcast && (any_mc_en || (amatch_en && da_ok));
      filter_addr_ok = by_addr || by_group || (bcast && bc_en);
   endfunction

   // Byte step runs every cycle; its result is kept only inside the window
   wfd_crc16_step u_crc (
      .crc_in(s_q.crc),
      .data(rx.data),
      .crc_out(crc_step)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [31:0] rd;
      logic wr;
      logic [15:0] rel;
      logic good;
      logic uni;
      logic bcast;
      logic mcast;
      logic filt_addr;
      logic [1:0] mi;
      s_d = s_q;
      rd = 32'h0000_0000;
      wr = 1'b0;
      rel = 16'h0000;
      good = 1'b0;
      uni = 1'b0;
      bcast = 1'b0;
      mcast = 1'b0;
      filt_addr = 1'b0;
      mi = 2'b00;

      // ----------------------------------------------------------------
      // Register read mux
      // ----------------------------------------------------------------
      if (apb_req.paddr == wfd_pkg::OFS_ADDR_A) begin
         rd[15:0] = s_q.addr[15:0];
      end else if (apb_req.paddr == wfd_pkg::OFS_ADDR_B) begin
         rd[15:0] = s_q.addr[31:16];
      end else if (apb_req.paddr == wfd_pkg::OFS_ADDR_C) begin
         rd[15:0] = s_q.addr[47:32];
      end else if (apb_req.paddr == wfd_pkg::OFS_WAKE_CS) begin
         rd[7:0] = s_q.wcs;
      end else if (apb_req.paddr == wfd_pkg::OFS_FCFG_A) begin
         rd[7:0] = s_q.offset;
         rd[wfd_pkg::CFGA_ADDR_MATCH] = s_q.amatch_en;
         rd[wfd_pkg::CFGA_ANY_MCAST] = s_q.any_mc_en;
         rd[wfd_pkg::CFGA_BCAST] = s_q.bc_en;
         rd[wfd_pkg::CFGA_TRIGGERED] = s_q.triggered;
         rd[wfd_pkg::CFGA_ENABLE] = s_q.filter_en;
      end else if (apb_req.paddr == wfd_pkg::OFS_FCFG_B) begin
         rd[15:0] = s_q.crc_exp;
      end else if (in_mask(apb_req.paddr)) begin
         mi = mask_word(apb_req.paddr);
         rd = s_q.mask[32 * mi +: 32];
      end else if (apb_req.paddr == wfd_pkg::OFS_IRQ_MASK) begin
         rd[wfd_pkg::IRQ_WAKE_BIT] = s_q.irq_mask;
      end else if (apb_req.paddr == wfd_pkg::OFS_IRQ_SRC) begin
         rd[wfd_pkg::IRQ_WAKE_BIT] = s_q.irq_src;
      end

      // ----------------------------------------------------------------
      // APB: no wait state, answer registered at the setup edge
      // ----------------------------------------------------------------
      s_d.rsp.pready = 1'b0;
      s_d.rsp.pslverr = 1'b0;
      s_d.rsp.prdata = 32'h0000_0000;
      if (apb_req.psel && !apb_req.penable) begin
         s_d.rsp.pready = 1'b1;
         s_d.rsp.pslverr = !reg_mapped(apb_req.paddr);
         if (reg_mapped(apb_req.paddr) && !apb_req.pwrite) begin
            s_d.rsp.prdata = rd;
         end
      end
      // Writes land at the access edge, when the registered ready is seen
      wr = apb_req.psel && apb_req.penable && s_q.rsp.pready && apb_req.pwrite
           && reg_mapped(apb_req.paddr);

      // ----------------------------------------------------------------
      // Register writes; status clears come before hardware sets
      // ----------------------------------------------------------------
      if (wr) begin
         if (apb_req.paddr == wfd_pkg::OFS_ADDR_A) begin
            s_d.addr[15:0] = apb_req.pwdata[15:0];
         end else if (apb_req.paddr == wfd_pkg::OFS_ADDR_B) begin
            s_d.addr[31:16] = apb_req.pwdata[15:0];
         end else if (apb_req.paddr == wfd_pkg::OFS_ADDR_C) begin
            s_d.addr[47:32] = apb_req.pwdata[15:0];
         end else if (apb_req.paddr == wfd_pkg::OFS_WAKE_CS) begin
            s_d.wcs[3:0] = apb_req.pwdata[3:0];
            s_d.wcs[7:4] = s_q.wcs[7:4] & ~apb_req.pwdata[7:4];
         end else if (apb_req.paddr == wfd_pkg::OFS_FCFG_A) begin
            s_d.offset = apb_req.pwdata[7:0];
            s_d.amatch_en = apb_req.pwdata[wfd_pkg::CFGA_ADDR_MATCH];
            s_d.any_mc_en = apb_req.pwdata[wfd_pkg::CFGA_ANY_MCAST];
            s_d.bc_en = apb_req.pwdata[wfd_pkg::CFGA_BCAST];
            s_d.filter_en = apb_req.pwdata[wfd_pkg::CFGA_ENABLE];
            if (apb_req.pwdata[wfd_pkg::CFGA_TRIGGERED]) begin
               s_d.triggered = 1'b0;
            end
         end else if (apb_req.paddr == wfd_pkg::OFS_FCFG_B) begin
            s_d.crc_exp = apb_req.pwdata[15:0];
         end else if (in_mask(apb_req.paddr)) begin
            s_d.mask[32 * mask_word(apb_req.paddr) +: 32] = apb_req.pwdata;
         end else if (apb_req.paddr == wfd_pkg::OFS_IRQ_MASK) begin
            s_d.irq_mask = apb_req.pwdata[wfd_pkg::IRQ_WAKE_BIT];
         end else if (apb_req.paddr == wfd_pkg::OFS_IRQ_SRC) begin
            if (apb_req.pwdata[wfd_pkg::IRQ_WAKE_BIT]) begin
               s_d.irq_src = 1'b0;
            end
         end
      end

      // ----------------------------------------------------------------
      // Frame end: decide and report
      // ----------------------------------------------------------------
      if (rx.frame_end) begin
         // A truncated destination address never wakes
         good = rx.fcs_ok && rx.len_ok && (s_q.idx >= wfd_pkg::DA_BYTES);
         bcast = s_q.bc_ok;
         mcast = s_q.mc && !bcast;
         uni = !s_q.mc;
         if (good && s_q.wcs[wfd_pkg::WCS_EXACT_EN] && s_q.da_ok) begin
            s_d.wcs[wfd_pkg::WCS_EXACT_SEEN] = 1'b1;
            s_d.irq_src = 1'b1;
         end
         if (good && s_q.wcs[wfd_pkg::WCS_BCAST_EN] && bcast) begin
            s_d.wcs[wfd_pkg::WCS_BCAST_SEEN] = 1'b1;
            s_d.irq_src = 1'b1;
         end
         if (good && s_q.wcs[wfd_pkg::WCS_PATTERN_EN] && s_q.pat_hit && (s_q.da_ok || bcast)) begin
            s_d.wcs[wfd_pkg::WCS_PATTERN_SEEN] = 1'b1;
            s_d.irq_src = 1'b1;
         end
         filt_addr = filter_addr_ok(uni, mcast, bcast, s_q.da_ok, s_q.amatch_en, s_q.any_mc_en,
                                    s_q.bc_en);
         if (good && s_q.wcs[wfd_pkg::WCS_FILTER_EN] && s_q.filter_en && filt_addr
             && (s_q.crc == s_q.crc_exp)) begin
            s_d.wcs[wfd_pkg::WCS_FILTER_SEEN] = 1'b1;
            s_d.triggered = 1'b1;
            s_d.irq_src = 1'b1;
         end
         // Clear per-frame state for the next frame
         s_d.idx = 16'h0000;
         s_d.da_ok = 1'b1;
         s_d.bc_ok = 1'b1;
         s_d.mc = 1'b0;
         s_d.pst = wfd_pkg::PAT_SEARCH;
         s_d.sync_cnt = 3'h0;
         s_d.pos = 3'h0;
         s_d.reps = 5'h00;
         s_d.pat_hit = 1'b0;
         s_d.crc = wfd_pkg::CRC_INIT;
      end else if (rx.valid) begin
         // ----------------------------------------------------------------
         // Byte in frame
         // ----------------------------------------------------------------
         if (s_q.idx < wfd_pkg::DA_BYTES) begin
            if (rx.data != addr_byte(s_q.addr, s_q.idx[2:0])) begin
               s_d.da_ok = 1'b0;
            end
            if (rx.data != wfd_pkg::ALL_ONES_BYTE) begin
               s_d.bc_ok = 1'b0;
            end
            // Group bit of the first destination byte
            if (s_q.idx == 16'h0000) begin
               s_d.mc = rx.data[0];
            end
         end

         // ----------------------------------------------------------------
         // Pattern search: sync run, then unbroken address copies
         // ----------------------------------------------------------------
         case (s_q.pst)
            wfd_pkg::PAT_SEARCH: begin
               if (rx.data == wfd_pkg::ALL_ONES_BYTE) begin
                  // Longer all-ones runs still count as one sync run
                  if (s_q.sync_cnt != wfd_pkg::SYNC_BYTES) begin
                     s_d.sync_cnt = s_q.sync_cnt + 3'h1;
                  end
               end else if (s_q.sync_cnt == wfd_pkg::SYNC_BYTES
                            && rx.data == addr_byte(s_q.addr, 3'h0)) begin
                  s_d.pst = wfd_pkg::PAT_COPIES;
                  s_d.pos = 3'h1;
                  s_d.reps = 5'h00;
                  s_d.sync_cnt = 3'h0;
               end else begin
                  s_d.sync_cnt = 3'h0;
               end
            end
            wfd_pkg::PAT_COPIES: begin
               if (rx.data == addr_byte(s_q.addr, s_q.pos)) begin
                  if (s_q.pos == wfd_pkg::LAST_ADDR_POS) begin
                     s_d.pos = 3'h0;
                     if (s_q.reps == wfd_pkg::LAST_REP) begin
                        s_d.pat_hit = 1'b1;
                        s_d.pst = wfd_pkg::PAT_SEARCH;
                     end else begin
                        s_d.reps = s_q.reps + 5'h01;
                     end
                  end else begin
                     s_d.pos = s_q.pos + 3'h1;
                  end
               end else begin
                  // Breaking byte may itself open a new sync run
                  s_d.pst = wfd_pkg::PAT_SEARCH;
                  s_d.sync_cnt = (rx.data == wfd_pkg::ALL_ONES_BYTE) ? 3'h1 : 3'h0;
                  s_d.pos = 3'h0;
                  s_d.reps = 5'h00;
               end
            end
            default: begin
               s_d.pst = wfd_pkg::PAT_SEARCH;
            end
         endcase

         // ----------------------------------------------------------------
         // Filter CRC over masked window; idx 0 is first destination byte
         // ----------------------------------------------------------------
         if (s_q.idx >= {8'h00, s_q.offset}) begin
            rel = s_q.idx - {8'h00, s_q.offset};
            if (rel < wfd_pkg::MASK_BITS && s_q.mask[rel[6:0]]) begin
               s_d.crc = crc_step;
            end
         end

         // Saturate so giant frames cannot wrap into the mask window
         if (s_q.idx != wfd_pkg::IDX_MAX) begin
            s_d.idx = s_q.idx + 16'h0001;
         end
      end

      // ----------------------------------------------------------------
      // Pins follow the sticky state, one flop deep
      // ----------------------------------------------------------------
      s_d.irq_n = !(s_d.irq_src && s_d.irq_mask);
      s_d.wake_n = !(|s_d.wcs[7:4]);
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         s_q <= '0;
         // Per-frame trackers idle at their frame-start values
         s_q.da_ok <= 1'b1;
         s_q.bc_ok <= 1'b1;
         s_q.pst <= wfd_pkg::PAT_SEARCH;
         s_q.crc <= wfd_pkg::CRC_INIT;
         s_q.irq_n <= 1'b1;
         s_q.wake_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign apb_rsp = s_q.rsp;
   assign irq_out_n = s_q.irq_n;
   assign wake_event_out_n = s_q.wake_n;
endmodule // wfd_detector

// *** common/wfd_pkg.sv ***
// Package for the wake frame detector: register map, field positions, types
package wfd_pkg;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_ADDR_A = 8'h00;
   localparam logic [7:0] OFS_ADDR_B = 8'h04;
   localparam logic [7:0] OFS_ADDR_C = 8'h08;
   localparam logic [7:0] OFS_WAKE_CS = 8'h0C;
   localparam logic [7:0] OFS_FCFG_A = 8'h10;
   localparam logic [7:0] OFS_FCFG_B = 8'h14;
   localparam logic [7:0] OFS_MASK0 = 8'h18;
   localparam logic [7:0] OFS_MASK3 = 8'h24;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
   localparam logic [7:0] OFS_IRQ_SRC = 8'h2C;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int unsigned WCS_EXACT_EN = 0;
   localparam int unsigned WCS_BCAST_EN = 1;
   localparam int unsigned WCS_PATTERN_EN = 2;
   localparam int unsigned WCS_FILTER_EN = 3;
   localparam int unsigned WCS_FILTER_SEEN = 4;
   localparam int unsigned WCS_PATTERN_SEEN = 5;
   localparam int unsigned WCS_BCAST_SEEN = 6;
   localparam int unsigned WCS_EXACT_SEEN = 7;
   localparam int unsigned CFGA_ADDR_MATCH = 8;
   localparam int unsigned CFGA_ANY_MCAST = 9;
   localparam int unsigned CFGA_BCAST = 10;
   localparam int unsigned CFGA_TRIGGERED = 24;
   localparam int unsigned CFGA_ENABLE = 31;
   localparam int unsigned IRQ_WAKE_BIT = 8;

   // ----------------------------------------------------------------
   // Values and counts
   // ----------------------------------------------------------------
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [7:0] ALL_ONES_BYTE = 8'hFF;
   localparam logic [15:0] DA_BYTES = 16'h0006;
   localparam logic [2:0] SYNC_BYTES = 3'h6;
   localparam logic [2:0] LAST_ADDR_POS = 3'h5;
   localparam logic [4:0] LAST_REP = 5'h0F;
   localparam logic [15:0] MASK_BITS = 16'h0080;
   localparam logic [15:0] IDX_MAX = 16'hFFFF;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [0:0] {
      PAT_SEARCH = 1'b0,
      PAT_COPIES = 1'b1
   } wfd_pat_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
      logic frame_end;
      logic fcs_ok;
      logic len_ok;
   } wfd_rx_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } wfd_apb_req_t;

   typedef struct packed {
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } wfd_apb_rsp_t;

   typedef struct packed {
      logic [47:0] addr;
      logic [7:0] wcs;
      logic [7:0] offset;
      logic amatch_en;
      logic any_mc_en;
      logic bc_en;
      logic triggered;
      logic filter_en;
      logic [15:0] crc_exp;
      logic [127:0] mask;
      logic irq_mask;
      logic irq_src;
      wfd_apb_rsp_t rsp;
      logic [15:0] idx;
      logic da_ok;
      logic bc_ok;
      logic mc;
      wfd_pat_t pst;
      logic [2:0] sync_cnt;
      logic [2:0] pos;
      logic [4:0] reps;
      logic pat_hit;
      logic [15:0] crc;
      logic irq_n;
      logic wake_n;
   } wfd_state_t;

endpackage

// *** core/wfd_crc16_step.sv ***
// One-byte update step of the wake filter CRC-16
`timescale 1ns/1ps
module wfd_crc16_step (
   // Running value and byte
   input wire logic [15:0] crc_in,
   input wire logic [7:0] data,
   // Updated value
   output logic [15:0] crc_out
);
   logic [7:0] f;

   always_comb begin
      f[0] = crc_in[15] ^ data[0];
      for (int i = 1; i < 8; i++) begin
         f[i] = crc_in[15 - i] ^ f[i - 1] ^ data[i];
      end
      crc_out[15] = crc_in[7] ^ f[7];
      crc_out[14:10] = crc_in[6:2];
      crc_out[9] = crc_in[1] ^ f[0];
      crc_out[8] = crc_in[0] ^ f[1];
      for (int i = 2; i < 8; i++) begin
         crc_out[9 - i] = f[i - 2] ^ f[i];
      end
      crc_out[1] = f[6];
      crc_out[0] = f[7];
   end
endmodule // wfd_crc16_step

// *** tb/wfd_assertions.sv ***
// Concurrent checks on the wake frame detector ports
`timescale 1ns/1ps
module wfd_chk (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Bus and frames
   input wire wfd_pkg::wfd_apb_req_t apb_req,
   input wire wfd_pkg::wfd_apb_rsp_t apb_rsp,
   input wire wfd_pkg::wfd_rx_t rx,
   // Pins
   input wire logic irq_out_n,
   input wire logic wake_event_out_n
);
   logic acc;
   logic good;
   logic clr_w;
   logic irq_w;
   assign acc = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
   assign good = rx.frame_end && rx.fcs_ok && rx.len_ok;
   assign clr_w = acc && apb_req.paddr == wfd_pkg::OFS_WAKE_CS && |apb_req.pwdata[7:4];
   assign irq_w = acc && (apb_req.paddr == wfd_pkg::OFS_IRQ_MASK || apb_req.paddr == wfd_pkg::OFS_IRQ_SRC);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   chk_setup_ready: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
      else $error("no ready after setup");
   chk_ready_once: assert property (apb_rsp.pready |=> !apb_rsp.pready)
      else $error("ready held too long");
   chk_bad_addr: assert property (apb_req.psel && !apb_req.penable &&
      (apb_req.paddr[1:0] != 2'h0 || apb_req.paddr > wfd_pkg::OFS_IRQ_SRC) |=> apb_rsp.pslverr)
      else $error("no error on unmapped address");
   chk_bad_frame: assert property (rx.frame_end && !(rx.fcs_ok && rx.len_ok) && wake_event_out_n
      |=> wake_event_out_n ##1 wake_event_out_n) else $error("bad frame woke");
   chk_wake_cause: assert property ($fell(wake_event_out_n) |-> $past(good))
      else $error("wake without good frame end");
   chk_wake_hold: assert property ($rose(wake_event_out_n) |-> $past(clr_w))
      else $error("wake dropped without clear");
   chk_irq_hold: assert property ($rose(irq_out_n) |-> $past(irq_w))
      else $error("interrupt dropped without clear");
   chk_irq_cause: assert property ($fell(irq_out_n) |-> $past(good) || $past(irq_w))
      else $error("interrupt without cause");
endmodule // wfd_chk

bind wfd_detector wfd_chk chk (.clock(clock), .rst_b(rst_b), .apb_req(apb_req), .apb_rsp(apb_rsp),
   .rx(rx), .irq_out_n(irq_out_n), .wake_event_out_n(wake_event_out_n));

// *** tb/wfd_frame_src.sv ***
// Received frame source standing in for the link side
`timescale 1ns/1ps
module wfd_frame_src (
   // Clock
   input wire logic clock,
   // Frame bytes
   output wfd_pkg::wfd_rx_t rx
);
   initial rx = '0;
   // Idle data is inverted so a stale byte never passes for a fresh one
   task automatic send(input logic [7:0] q[$], input logic fcs, input logic len, input logic slow);
      foreach (q[i]) begin
         @(posedge clock);
         rx.valid <= 1'b1;
         rx.data <= q[i];
         if (slow) begin
            @(posedge clock);
            rx.valid <= 1'b0;
            rx.data <= ~q[i];
         end
      end
      @(posedge clock);
      rx <= '{valid: 1'b0, data: ~rx.data, frame_end: 1'b1, fcs_ok: fcs, len_ok: len};
      @(posedge clock);
      rx <= '{valid: 1'b0, data: rx.data, frame_end: 1'b0, fcs_ok: ~fcs, len_ok: ~len};
   endtask
endmodule // wfd_frame_src

// *** tb/tb_wfd_detector.sv ***
// Self-checking bench for the wake frame detector
`timescale 1ns/1ps
module tb_wfd_detector;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   wfd_pkg::wfd_apb_req_t apb_req = '0;
   wfd_pkg::wfd_apb_rsp_t apb_rsp;
   wfd_pkg::wfd_rx_t rx;
   logic irq_out_n;
   logic wake_event_out_n;
   int errors = 0;
   int tests_run = 0;
   logic [7:0] adr [6];
   logic [7:0] fr [$];
   logic [31:0] rd;
   logic err;

   always #5 clock = ~clock;

   wfd_detector dut (.clock(clock), .rst_b(rst_b), .apb_req(apb_req), .apb_rsp(apb_rsp), .rx(rx),
      .irq_out_n(irq_out_n), .wake_event_out_n(wake_event_out_n));
   wfd_frame_src src (.clock(clock), .rx(rx));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge clock);
      apb_req.penable <= 1'b1;
      // Only the watchdog ends a wait for ready
      do begin
         @(posedge clock);
      end while (apb_rsp.pready !== 1'b1);
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
      logic [7:0] f;
      logic [15:0] n;
      f[0] = c[15] ^ d[0];
      for (int i = 1; i < 8; i++) f[i] = c[15 - i] ^ f[i - 1] ^ d[i];
      n = {c[7] ^ f[7], c[6:2], c[1] ^ f[0], c[0] ^ f[1], 8'h00};
      for (int k = 0; k < 6; k++) n[7 - k] = f[k] ^ f[k + 2];
      n[1:0] = {f[6], f[7]};
      return n;
   endfunction

   // Kinds: 0 own unicast, 1 other unicast, 2 multicast, 3 broadcast
   function automatic logic filt_exp(input logic [1:0] k, input logic [2:0] cfg);
      return k == 2'h0 || (k == 2'h1 && !cfg[0]) || (k == 2'h2 && cfg[1]) || (k == 2'h3 && cfg[2]);
   endfunction

   task automatic put_da(input logic [1:0] k, input int n);
      fr = {};
      foreach (adr[i]) fr.push_back(k == 2'h3 ? 8'hFF : adr[i]);
      if (k == 2'h1) fr[5] = ~fr[5];
      if (k == 2'h2) fr[0][0] = 1'b1;
      repeat (n) fr.push_back(8'($urandom));
   endtask

   task automatic reps(input int n);
      repeat (n) foreach (adr[i]) fr.push_back(adr[i]);
   endtask

   // Clearing status first leaves the interrupt up until its own clear
   task automatic expect_wake(input logic [3:0] st, input logic [3:0] en);
      apb(1'b0, wfd_pkg::OFS_WAKE_CS, 32'h0);
      chk(rd, {24'h0, st, en});
      chk({wake_event_out_n, irq_out_n}, {2{st == 4'h0}});
      apb(1'b1, wfd_pkg::OFS_WAKE_CS, {24'h0, 4'hF, en});
      repeat (2) @(posedge clock);
      chk({wake_event_out_n, irq_out_n}, {1'b1, st == 4'h0});
      apb(1'b1, wfd_pkg::OFS_IRQ_SRC, 32'h100);
      repeat (2) @(posedge clock);
      chk({31'h0, irq_out_n}, 32'h1);
   endtask

   task automatic close_out();
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge clock);
      errors++;
      close_out();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] msk [4];
      logic [7:0] ofs;
      logic [15:0] crc;
      logic [2:0] cfg;
      logic [1:0] kind;
      logic good;
      void'($urandom(10));
      repeat (20) @(posedge clock);
      rst_b <= 1'b1;
      chk({wake_event_out_n, irq_out_n}, 32'h3);
      apb(1'b0, wfd_pkg::OFS_WAKE_CS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h30, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, 8'h01, 32'hFFFFFFFF);
      chk({31'h0, err}, 32'h1);
      foreach (adr[i]) adr[i] = 8'($urandom);
      adr[0][0] = 1'b0;
      for (int i = 0; i < 3; i++) apb(1'b1, 8'(4 * i), {16'h0, adr[2 * i + 1], adr[2 * i]});
      apb(1'b0, wfd_pkg::OFS_ADDR_C, 32'h0);
      chk(rd, {16'h0, adr[5], adr[4]});
      apb(1'b1, wfd_pkg::OFS_WAKE_CS, 32'h1);
      apb(1'b1, wfd_pkg::OFS_IRQ_MASK, 32'h100);
      put_da(2'h0, 20);
      src.send(fr, 1'b0, 1'b1, 1'b0);
      expect_wake(4'h0, 4'h1);
      src.send(fr, 1'b1, 1'b1, 1'b1);
      expect_wake(4'h8, 4'h1);
      put_da(2'h1, 20);
      src.send(fr, 1'b1, 1'b1, 1'b0);
      expect_wake(4'h0, 4'h1);
      apb(1'b1, wfd_pkg::OFS_WAKE_CS, 32'h2);
      put_da(2'h3, 10);
      src.send(fr, 1'b1, 1'b0, 1'b0);
      expect_wake(4'h0, 4'h2);
      src.send(fr, 1'b1, 1'b1, 1'b0);
      expect_wake(4'h4, 4'h2);
      apb(1'b1, wfd_pkg::OFS_WAKE_CS, 32'h4);
      for (int t = 0; t < 5; t++) begin
         put_da(t == 3 ? 2'h1 : 2'h0, 6);
         if (t != 4) repeat (6) fr.push_back(8'hFF);
         if (t == 1) begin
            reps(7);
            fr.push_back(adr[0] ^ 8'h10);
            repeat (6) fr.push_back(8'hFF);
         end
         reps(t == 2 ? 15 : 16);
         repeat (4) fr.push_back(8'h00);
         src.send(fr, 1'b1, 1'b1, t[0]);
         expect_wake(t < 2 ? 4'h2 : 4'h0, 4'h4);
      end
      apb(1'b1, wfd_pkg::OFS_WAKE_CS, 32'h8);
      for (int t = 0; t < 12; t++) begin
         cfg = 3'($urandom);
         kind = 2'($urandom);
         ofs = 8'($urandom_range(15));
         good = $urandom_range(3) != 0;
         foreach (msk[i]) msk[i] = $urandom;
         put_da(kind, 150);
         crc = 16'hFFFF;
         for (int j = 0; j < 128; j++) if (msk[j / 32][j % 32]) crc = crc_step(crc, fr[ofs + j]);
         foreach (msk[i]) apb(1'b1, wfd_pkg::OFS_MASK0 + 8'(4 * i), msk[i]);
         apb(1'b1, wfd_pkg::OFS_FCFG_B, {16'h0, good ? crc : ~crc});
         apb(1'b1, wfd_pkg::OFS_FCFG_A, {7'h00, 1'b1, 13'h0, cfg, ofs});
         apb(1'b1, wfd_pkg::OFS_FCFG_A, {8'h80, 13'h0, cfg, ofs});
         src.send(fr, 1'b1, 1'b1, t[0]);
         apb(1'b0, wfd_pkg::OFS_FCFG_A, 32'h0);
         chk(rd, {7'h40, good && filt_exp(kind, cfg), 13'h0, cfg, ofs});
         expect_wake({3'h0, good && filt_exp(kind, cfg)}, 4'h8);
      end
      close_out();
   end
endmodule // tb_wfd_detector
